// ### read_latency_config_map_bench.sv
`timescale 1ns/1ps
`default_nettype none
module read_latency_config_map_bench
   import rlc_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic        req = 1'b0;
   rlc_cmd_t    cmd = RLC_CMD_WRITE;
   logic [23:0] addr = 24'h00_0000;
   logic [7:0]  wdata = 8'h00;
   logic [4:0]  dummy = 5'h00;
   logic        busy;
   logic        done;
   logic [7:0]  rdata;
   logic [7:0]  cfg_nv;
   logic [7:0]  cfg_v;
   logic [4:0]  dummy_now;
   logic        lat_valid;
   int          n_mismatch = 0;
   int          total_checks = 0;
   logic [6:0]  n_strobe = 7'h00;
   logic [6:0]  oe_at = 7'h00;
   logic [4:0]  oe_lat;
   always #12.5 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////
   rlc_link_if rlc_link_if_inst ();
   rlc_dev rlc_dev_inst (.CLK_SYS(clk_sys), .RST_B(rst_b),
      .LINK(rlc_link_if_inst), .CFG2_NV(cfg_nv), .CFG2_V(cfg_v),
      .DUMMY_NOW(dummy_now), .LAT_VALID(lat_valid));
   rlc_host rlc_host_inst (.CLK_SYS(clk_sys), .RST_B(rst_b),
      .LINK(rlc_link_if_inst), .REQ(req), .CMD(cmd), .ADDR(addr),
      .WDATA(wdata), .DUMMY(dummy), .BUSY(busy), .DONE(done),
      .RDATA(rdata));
   rlc_link_sva rlc_link_sva_inst (.CLK_SYS(clk_sys), .RST_B(rst_b),
      .cs_n(rlc_link_if_inst.cs_n), .sck_en(rlc_link_if_inst.sck_en),
      .mosi(rlc_link_if_inst.mosi), .miso(rlc_link_if_inst.miso),
      .miso_oe(rlc_link_if_inst.miso_oe));
   // strobes the host has sent when the device first drives miso
   always @(posedge clk_sys) begin
      if (rlc_link_if_inst.cs_n)
         n_strobe <= 7'h00;
      else if (rlc_link_if_inst.sck_en)
         n_strobe <= n_strobe + 7'h01;
      if (!rlc_link_if_inst.cs_n && !rlc_link_if_inst.miso_oe)
         oe_at <= n_strobe;
   end
   assign oe_lat = 5'(oe_at - 7'h20);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk_byte(input string s, input logic [7:0] e,
                           input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic chk_cnt(input string s, input logic [4:0] e,
                          input logic [4:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0d seen %0d", s, e, g);
      end
   endtask
   task automatic chk_bit(input string s, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %b seen %b", s, e, g);
      end
   endtask
   // one command; the device updates a few clocks after DONE (2-flop sync)
   task automatic run(input rlc_cmd_t c, input logic [23:0] a,
                      input logic [7:0] d, input logic [4:0] n);
      int k;
      @(posedge clk_sys);
      cmd <= c;
      addr <= a;
      wdata <= d;
      dummy <= n;
      req <= 1'b1;
      @(posedge clk_sys);
      req <= 1'b0;
      #1;
      chk_bit("busy", 1'b1, busy);
      k = 0;
      while (done !== 1'b1 && k < 1000) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      chk_bit("done", 1'b1, done);
      chk_bit("idle", 1'b0, busy);
      repeat (8) @(posedge clk_sys);
      #1;
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #400000;
      n_mismatch++;
      final_report();
   end
   initial begin
      logic [4:0] pat [7] = '{5'h0E, 5'h0C, 5'h0A, 5'h08, 5'h06, 5'h04,
                              5'h02};
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      chk_byte("nv reset", 8'h08, cfg_nv);
      chk_byte("v reset", 8'h08, cfg_v);
      chk_cnt("dummy reset", 5'h08, dummy_now);
      chk_bit("valid reset", 1'b1, lat_valid);
      run(RLC_CMD_READ, 24'h00_0003, 8'h00, 5'h00);
      chk_byte("read nv", 8'h08, rdata);
      chk_cnt("reg latency", 5'h00, oe_lat);
      $display("test reset done");
      // pattern value equals its dummy count for every supported setting
      for (int i = 0; i < 7; i++) begin
         run(RLC_CMD_WRITE, 24'h80_0003, {3'h0, pat[i]}, 5'h00);
         chk_cnt("dummy", pat[i], dummy_now);
         chk_bit("valid", 1'b1, lat_valid);
         run(RLC_CMD_READ, 24'h80_0003, 8'h00, 5'h00);
         chk_byte("read v", {3'h0, pat[i]}, rdata);
         run(RLC_CMD_DATA, 24'h00_0000, 8'h00, pat[i]);
         chk_byte("array", 8'h00, rdata);
         chk_cnt("latency", pat[i], oe_lat);
      end
      $display("test patterns done");
      run(RLC_CMD_WRITE, 24'h80_0003, 8'hFF, 5'h00);
      chk_byte("v masked", 8'h0F, cfg_v);
      chk_cnt("dummy off", 5'h00, dummy_now);
      chk_bit("valid off", 1'b0, lat_valid);
      $display("test unsupported done");
      run(RLC_CMD_WRITE, 24'h00_0003, 8'h0C, 5'h00);
      chk_byte("nv write", 8'h0C, cfg_nv);
      chk_cnt("dummy nv", 5'h0C, dummy_now);
      run(RLC_CMD_WRITE, 24'h80_0003, 8'h06, 5'h00);
      chk_byte("nv kept", 8'h0C, cfg_nv);
      $display("test copies done");
      run(RLC_CMD_WRITE, 24'h00_0004, 8'h02, 5'h00);
      chk_byte("v kept", 8'h06, cfg_v);
      run(RLC_CMD_READ, 24'h00_0004, 8'h00, 5'h00);
      chk_byte("unmapped", 8'h00, rdata);
      $display("test addressing done");
      final_report();
   end
endmodule
`default_nettype wire

// ### rlc_consts.svh
`ifndef RLC_CONSTS_SVH
`define RLC_CONSTS_SVH

// command opcodes
`define RLC_OP_WRITE_REG   8'h71
`define RLC_OP_READ_REG    8'h65
`define RLC_OP_READ_DATA   8'h0B

// register addresses (24 bit)
`define RLC_ADDR_CFG2_NV   24'h00_0003
`define RLC_ADDR_CFG2_V    24'h80_0003

// latency field position and width
`define RLC_LAT_LSB        0
`define RLC_LAT_W          4

// latency field encodings (5-bit patterns, field keeps low 4 bits)
`define RLC_PAT_14         5'h0E
`define RLC_PAT_12         5'h0C
`define RLC_PAT_10         5'h0A
`define RLC_PAT_8          5'h08
`define RLC_PAT_6          5'h06
`define RLC_PAT_4          5'h04
`define RLC_PAT_2          5'h02

// reset value and write mask
`define RLC_CFG2_RST       8'h08
`define RLC_CFG2_MASK      8'h0F

`endif

// ### rlc_dev.sv
// Notes on behaviour
// - 71h writes register named by address
// - 65h reads register named by address
// - persistent latency copy at address 03h
// - four-bit latency field starting at bit 0
// - latency reachable only through addressed commands
// - counts 16 and above never supported
// - pattern 01110b selects 14 dummy cycles
// - pattern 01100b selects 12, supported
// - pattern 01010b selects 10, supported
// - pattern 01000b selects 8, supported
// - pattern 00110b selects 6, supported
// - pattern 00100b selects 4, supported
// - pattern 00010b selects 2, supported
// - volatile copy at 800003h, same field
`timescale 1ns/1ps
`default_nettype none
`include "rlc_consts.svh"
module rlc_dev
   import rlc_pkg::*;
(
   input  wire logic  CLK_SYS,     // system clock
   input  wire logic  RST_B,       // async reset, active low
   rlc_link_if.dev    LINK,        // serial link to host
   output logic [7:0] CFG2_NV,     // persistent register copy
   output logic [7:0] CFG2_V,      // volatile register copy
   output logic [4:0] DUMMY_NOW,   // dummy cycles in force
   output logic       LAT_VALID    // volatile pattern is supported
);

////////////////////////////////////////////////////////////////////////
// link inputs pass two flops, though the host runs on the same CLK_SYS here
logic [2:0] s1;
logic [2:0] s2;
always_ff @(posedge CLK_SYS or negedge RST_B) begin
   if (!RST_B) begin
      s1 <= 3'b001;
      s2 <= 3'b001;
   end else begin
      s1 <= {LINK.mosi, LINK.sck_en, LINK.cs_n};
      s2 <= s1;
   end
end
wire cs_n = s2[0];
wire bit_en = s2[1];
wire din = s2[2];

////////////////////////////////////////////////////////////////////////
// pattern decode; unsupported patterns give zero
function automatic logic [4:0] lat_of(input logic [3:0] f);
   logic [4:0] p;
   p = {1'b0, f};
   case (p)
      `RLC_PAT_14: lat_of = 5'd14;
      `RLC_PAT_12: lat_of = 5'd12;
      `RLC_PAT_10: lat_of = 5'd10;
      `RLC_PAT_8:  lat_of = 5'd8;
      `RLC_PAT_6:  lat_of = 5'd6;
      `RLC_PAT_4:  lat_of = 5'd4;
      `RLC_PAT_2:  lat_of = 5'd2;
      default:     lat_of = 5'd0;
   endcase
endfunction

// only the three addressed commands open a frame; anything else is skipped
function automatic logic op_known(input logic [7:0] o);
   op_known = (o == `RLC_OP_WRITE_REG) ||
              (o == `RLC_OP_READ_REG) ||
              (o == `RLC_OP_READ_DATA);
endfunction

////////////////////////////////////////////////////////////////////////
// frame engine: deselect rearms for a fresh opcode, so a cut frame
// leaves nothing half done
rlc_state_t  st;
logic [7:0]  op;
logic [23:0] addr;
logic [7:0]  sh;
logic [5:0]  cnt;
logic [7:0]  rd;

wire [7:0]  sh_in = {sh[6:0], din};
wire [23:0] ad_in = {addr[22:0], din};
wire        byte_done = (cnt[2:0] == 3'd7);
wire        last_addr = (cnt == 6'd23);
wire [4:0]  lat = lat_of(CFG2_V[`RLC_LAT_LSB +: `RLC_LAT_W]);

// one address decode, shared by reads and writes so they cannot drift
function automatic logic [1:0] reg_hit(input logic [23:0] a);
   reg_hit = 2'b00;
   if (a == `RLC_ADDR_CFG2_NV)
      reg_hit[0] = 1'b1;
   if (a == `RLC_ADDR_CFG2_V)
      reg_hit[1] = 1'b1;
endfunction

function automatic logic [7:0] reg_sel(input logic [23:0] a,
                                       input logic [7:0] nv,
                                       input logic [7:0] v);
   logic [1:0] h;
   h = reg_hit(a);
   if (h[0])
      reg_sel = nv;
   else if (h[1])
      reg_sel = v;
   else
      reg_sel = 8'h00;
endfunction

always_ff @(posedge CLK_SYS or negedge RST_B) begin
   if (!RST_B) begin
      st   <= RLC_ST_IDLE;
      op   <= 8'h00;
      addr <= 24'h00_0000;
      sh   <= 8'h00;
      cnt  <= 6'd0;
      rd   <= 8'h00;
   end else if (cs_n) begin
      st  <= RLC_ST_OP;
      cnt <= 6'd0;
   end else if (bit_en) begin
      case (st)
         RLC_ST_OP: begin
            sh  <= sh_in;
            cnt <= cnt + 6'd1;
            if (byte_done) begin
               op  <= sh_in;
               cnt <= 6'd0;
               if (op_known(sh_in))
                  st <= RLC_ST_ADDR;
               else
                  st <= RLC_ST_IDLE;
            end
         end
         RLC_ST_ADDR: begin
            addr <= ad_in;
            cnt  <= cnt + 6'd1;
            if (last_addr) begin
               cnt <= 6'd0;
               if (op == `RLC_OP_WRITE_REG)
                  st <= RLC_ST_WDATA;
               else if (op == `RLC_OP_READ_DATA && lat != 5'd0)
                  st <= RLC_ST_DUMMY;
               else begin
                  st <= RLC_ST_RDATA;
                  rd <= (op == `RLC_OP_READ_REG) ?
                        reg_sel(ad_in, CFG2_NV, CFG2_V) : 8'h00;
               end
            end
         end
         RLC_ST_WDATA: begin
            sh  <= sh_in;
            cnt <= cnt + 6'd1;
            if (byte_done)
               st <= RLC_ST_IDLE;
         end
         RLC_ST_DUMMY: begin
            cnt <= cnt + 6'd1;
            if (cnt == {1'b0, lat - 5'd1}) begin
               cnt <= 6'd0;
               st  <= RLC_ST_RDATA;
               rd  <= 8'h00;
            end
         end
         RLC_ST_RDATA: begin
            rd  <= {rd[6:0], 1'b0};
            cnt <= cnt + 6'd1;
         end
         default: st <= RLC_ST_IDLE;
      endcase
   end
end

////////////////////////////////////////////////////////////////////////
// register writes; only low field bits are kept, the rest read zero
wire wr_done = !cs_n && bit_en && st == RLC_ST_WDATA && byte_done;
wire [1:0] wr_hit = reg_hit(addr);
always_ff @(posedge CLK_SYS or negedge RST_B) begin
   if (!RST_B) begin
      CFG2_NV <= `RLC_CFG2_RST;
      CFG2_V  <= `RLC_CFG2_RST;
   end else if (wr_done) begin
      // a persistent write refreshes the working copy as well
      if (wr_hit[0]) begin
         CFG2_NV <= sh_in & `RLC_CFG2_MASK;
         CFG2_V  <= sh_in & `RLC_CFG2_MASK;
      end else if (wr_hit[1]) begin
         CFG2_V  <= sh_in & `RLC_CFG2_MASK;
      end
   end
end

always_ff @(posedge CLK_SYS or negedge RST_B) begin
   if (!RST_B) begin
      DUMMY_NOW <= 5'd0;
      LAT_VALID <= 1'b0;
   end else begin
      // held in flops so users see a clean level, one clock after a write
      DUMMY_NOW <= lat;
      LAT_VALID <= (lat != 5'd0);
   end
end

assign LINK.miso    = rd[7];
// enable follows the synchronised select, so it drops two clocks late
assign LINK.miso_oe = !cs_n && st == RLC_ST_RDATA;

endmodule
`default_nettype wire

// ### rlc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "rlc_consts.svh"
module rlc_host
   import rlc_pkg::*;
(
   input  wire logic        CLK_SYS,   // system clock
   input  wire logic        RST_B,     // async reset, active low
   rlc_link_if.host         LINK,      // serial link to device
   input  wire logic        REQ,       // start a command
   input  wire rlc_cmd_t    CMD,       // command kind
   input  wire logic [23:0] ADDR,      // register or array address
   input  wire logic [7:0]  WDATA,     // write byte
   input  wire logic [4:0]  DUMMY,     // dummy cycles for array reads
   output logic             BUSY,      // command in progress
   output logic             DONE,      // one-cycle completion pulse
   output logic [7:0]       RDATA      // byte read back
);

// each link bit lasts SLOW clocks so the device synchroniser keeps up
localparam int SLOW = 4;

rlc_state_t  st;
logic [7:0]  op;
logic [39:0] tx;
logic [5:0]  cnt;
logic [4:0]  dmy;
logic [1:0]  ph;
logic [7:0]  rx;
logic        m1;
logic        m2;
// a read bit returns through both synchronisers one clock after the
// next strobe, so it is taken on the clock after that strobe
logic        grab;

always_ff @(posedge CLK_SYS or negedge RST_B) begin
   if (!RST_B) begin
      m1 <= 1'b0;
      m2 <= 1'b0;
   end else begin
      m1 <= LINK.miso;
      m2 <= m1;
   end
end

wire tick = (ph == 2'(SLOW - 1));

always_ff @(posedge CLK_SYS or negedge RST_B) begin
   if (!RST_B) begin
      st <= RLC_ST_IDLE;
      op <= 8'h00;
      tx <= 40'h00_0000_0000;
      cnt <= 6'd0;
      dmy <= 5'd0;
      ph <= 2'd0;
      rx <= 8'h00;
      RDATA <= 8'h00;
      DONE <= 1'b0;
      grab <= 1'b0;
   end else begin
      DONE <= 1'b0;
      ph <= (st == RLC_ST_IDLE) ? 2'd0 : ph + 2'd1;
      grab <= tick && st == RLC_ST_RDATA;
      case (st)
         RLC_ST_IDLE: if (REQ) begin
            // register access always carries an address
            case (CMD)
               RLC_CMD_WRITE: op <= `RLC_OP_WRITE_REG;
               RLC_CMD_READ:  op <= `RLC_OP_READ_REG;
               default:       op <= `RLC_OP_READ_DATA;
            endcase
            tx <= {(CMD == RLC_CMD_WRITE) ? `RLC_OP_WRITE_REG :
                   (CMD == RLC_CMD_READ) ? `RLC_OP_READ_REG :
                   `RLC_OP_READ_DATA, ADDR, WDATA};
            dmy <= (CMD == RLC_CMD_DATA) ? DUMMY : 5'd0;
            cnt <= 6'd0;
            st <= RLC_ST_OP;
         end
         RLC_ST_OP: if (tick) begin
            tx <= {tx[38:0], 1'b0};
            cnt <= cnt + 6'd1;
            if (cnt == 6'd31) begin
               cnt <= 6'd0;
               if (op == `RLC_OP_WRITE_REG)
                  st <= RLC_ST_WDATA;
               else if (dmy != 5'd0)
                  st <= RLC_ST_DUMMY;
               else
                  st <= RLC_ST_RDATA;
            end
         end
         RLC_ST_WDATA: if (tick) begin
            tx <= {tx[38:0], 1'b0};
            cnt <= cnt + 6'd1;
            if (cnt == 6'd7) begin
               st <= RLC_ST_IDLE;
               DONE <= 1'b1;
            end
         end
         RLC_ST_DUMMY: if (tick) begin
            cnt <= cnt + 6'd1;
            if (cnt == {1'b0, dmy - 5'd1}) begin
               cnt <= 6'd0;
               st <= RLC_ST_RDATA;
            end
         end
         RLC_ST_RDATA: begin
            if (tick)
               cnt <= cnt + 6'd1;
            if (grab) begin
               rx <= {rx[6:0], m2};
               if (cnt == 6'd8) begin
                  RDATA <= {rx[6:0], m2};
                  st <= RLC_ST_IDLE;
                  DONE <= 1'b1;
               end
            end
         end
         default: st <= RLC_ST_IDLE;
      endcase
   end
end

assign BUSY = (st != RLC_ST_IDLE);
assign LINK.cs_n = (st == RLC_ST_IDLE);
assign LINK.sck_en = tick && BUSY;
assign LINK.mosi = tx[39];

endmodule
`default_nettype wire

// ### rlc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rlc_link_if;
   logic cs_n;
   logic sck_en;
   logic mosi;
   logic miso;
   logic miso_oe;

   modport dev  (input cs_n, input sck_en, input mosi,
                 output miso, output miso_oe);
   modport host (output cs_n, output sck_en, output mosi,
                 input miso, input miso_oe);
endinterface
`default_nettype wire

// ### rlc_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rlc_link_sva (
   input wire logic CLK_SYS, // system clock
   input wire logic RST_B,   // async reset, low
   input wire logic cs_n,    // select, low
   input wire logic sck_en,  // bit strobe
   input wire logic mosi,    // host data
   input wire logic miso,    // device data
   input wire logic miso_oe  // device drives miso
);
   default clocking dck @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   ////////////////////////////////////////////////////////////////////////
   logic [6:0] nbit; // strobes in this frame
   logic [7:0] op;   // first byte of the frame
   // count holds through the edge where cs_n rises, so frame length is seen
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         nbit <= 7'h00;
      end else if (cs_n) begin
         nbit <= 7'h00;
      end else if (sck_en) begin
         nbit <= nbit + 7'h01;
      end
   end
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         op <= 8'h00;
      end else if (!cs_n && sck_en && nbit < 7'h08) begin
         op <= {op[6:0], mosi};
      end
   end
   sequence s_gap;
      !sck_en [*3];
   endsequence
   // device sees cs_n through two flops, so release may lag
   sequence s_release;
      ##[1:4] !miso_oe;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_strobe_sel: assert property (
      sck_en |-> !cs_n) else $error("strobe while deselected");
   a_strobe_gap: assert property (
      sck_en |=> s_gap) else $error("strobes too close");
   a_opcode_legal: assert property (
      !cs_n && nbit == 7'h08 |-> op inside {8'h71, 8'h65, 8'h0B})
      else $error("unknown opcode sent");
   a_write_len: assert property (
      $rose(cs_n) && op == 8'h71 |-> nbit == 7'h28)
      else $error("write frame length wrong");
   a_read_len: assert property (
      $rose(cs_n) && op == 8'h65 |-> nbit == 7'h28)
      else $error("register read length wrong");
   a_oe_after_addr: assert property (
      miso_oe && !cs_n |-> nbit >= 7'h20)
      else $error("device drove before address end");
   a_write_no_oe: assert property (
      !cs_n && op == 8'h71 && nbit > 7'h08 |-> !miso_oe)
      else $error("device drove during write");
   a_oe_release: assert property (
      $rose(cs_n) |-> s_release) else $error("miso not released");
   a_array_zero: assert property (
      miso_oe && op == 8'h0B |-> !miso)
      else $error("array read returned data");
endmodule
`default_nettype wire

// ### rlc_pkg.sv
`default_nettype none
package rlc_pkg;
   typedef enum logic [1:0] {
      RLC_CMD_WRITE = 2'b00,
      RLC_CMD_READ  = 2'b01,
      RLC_CMD_DATA  = 2'b10
   } rlc_cmd_t;

   typedef enum logic [2:0] {
      RLC_ST_IDLE  = 3'b000,
      RLC_ST_OP    = 3'b001,
      RLC_ST_ADDR  = 3'b010,
      RLC_ST_WDATA = 3'b011,
      RLC_ST_DUMMY = 3'b100,
      RLC_ST_RDATA = 3'b101
   } rlc_state_t;
endpackage
`default_nettype wire
